// ===== pcr_pkg.sv
package pcr_pkg;

  // Port count and bus widths
  localparam int PCR_NUM_PORTS = 4;
  localparam int PCR_ADDR_W = 8;
  localparam int PCR_DATA_W = 8;
  localparam int PCR_RESULT_W = 3;
  localparam int PCR_CNT_W = 32;

  // Byte offsets on the management bus
  localparam logic [7:0] PCR_ADDR_MODE = 8'h12;
  localparam logic [7:0] PCR_ADDR_DISC = 8'h13;
  localparam logic [7:0] PCR_ADDR_DCEN = 8'h14;
  localparam logic [7:0] PCR_ADDR_BACKOFF = 8'h15;
  localparam logic [7:0] PCR_ADDR_TIMING = 8'h16;
  localparam logic [7:0] PCR_ADDR_DETACT = 8'h18;

  // Reset values
  localparam logic [7:0] PCR_RST_MODE = 8'h00;
  localparam logic [7:0] PCR_RST_DISC = 8'h00;
  localparam logic [7:0] PCR_RST_DCEN = 8'h00;
  localparam logic [3:0] PCR_RST_BACKOFF = 4'h0;
  localparam logic [7:0] PCR_RST_TIMING = 8'h00;
  localparam logic [7:0] PCR_RD_ZERO = 8'h00;

  // Field layout
  localparam int PCR_MODE_W = 2;
  localparam int PCR_HI_LSB = 4;
  localparam int PCR_TSEL_W = 2;
  localparam int PCR_TSEL_START_LSB = 0;
  localparam int PCR_TSEL_CUT_LSB = 2;
  localparam int PCR_TSEL_DIS_LSB = 4;
  localparam int PCR_DETCHG_BIT = 6;
  localparam int PCR_INTEN_BIT = 7;

  // Port operating modes
  typedef enum logic [1:0] {
    PCR_MODE_SHUTDOWN = 2'b00,
    PCR_MODE_MANUAL = 2'b01,
    PCR_MODE_SOFTWARE = 2'b10,
    PCR_MODE_HARDWARE = 2'b11
  } pcr_mode_e;

  // Clock rate and times in milliseconds
  localparam int PCR_CLK_HZ = 200_000_000;
  localparam int PCR_HZ_PER_KHZ = 1000;
  localparam int PCR_CYC_PER_MS = PCR_CLK_HZ / PCR_HZ_PER_KHZ;
  localparam logic [31:0] PCR_BACKOFF_MS = 32'h0000_09C4; // 2500 ms
  localparam logic [31:0] PCR_T60_MS = 32'h0000_003C;
  localparam logic [31:0] PCR_T30_MS = 32'h0000_001E;
  localparam logic [31:0] PCR_T120_MS = 32'h0000_0078;
  localparam logic [31:0] PCR_T240_MS = 32'h0000_00F0;
  localparam logic [31:0] PCR_T360_MS = 32'h0000_0168;
  localparam logic [31:0] PCR_T90_MS = 32'h0000_005A;
  localparam logic [31:0] PCR_T180_MS = 32'h0000_00B4;
  localparam logic [31:0] PCR_T720_MS = 32'h0000_02D0;

  // Start and cut timer length in ms
  function automatic logic [31:0] pcr_start_ms(input logic [1:0] sel);
    logic [31:0] ms;
    unique case (sel)
      2'b00: ms = PCR_T60_MS;
      2'b01: ms = PCR_T30_MS;
      2'b10: ms = PCR_T120_MS;
      2'b11: ms = PCR_T240_MS;
    endcase
    return ms;
  endfunction : pcr_start_ms

  // Disconnect timer length in ms
  function automatic logic [31:0] pcr_dis_ms(input logic [1:0] sel);
    logic [31:0] ms;
    unique case (sel)
      2'b00: ms = PCR_T360_MS;
      2'b01: ms = PCR_T90_MS;
      2'b10: ms = PCR_T180_MS;
      2'b11: ms = PCR_T720_MS;
    endcase
    return ms;
  endfunction : pcr_dis_ms

endpackage : pcr_pkg

// ===== pcr_port_seq.sv
`timescale 1ns/10ps
module pcr_port_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire pcr_pkg::pcr_mode_e mode,
  input wire logic sig_en,
  input wire logic cls_en,
  input wire logic backoff_en,
  input wire logic detect_change,
  input wire logic [pcr_pkg::PCR_CNT_W-1:0] backoff_cycles,
  // Measurement engine
  input wire logic sig_done,
  input wire logic [pcr_pkg::PCR_RESULT_W-1:0] sig_result,
  input wire logic cls_done,
  output logic sig_req,
  output logic cls_req,
  // Events and one-shot clears
  output logic det_event,
  output logic clr_sig,
  output logic clr_cls
);
  import pcr_pkg::*;

  typedef enum logic [1:0] {
    PCR_SEQ_IDLE = 2'b00,
    PCR_SEQ_SIG = 2'b01,
    PCR_SEQ_CLS = 2'b10,
    PCR_SEQ_GAP = 2'b11
  } pcr_seq_e;

  pcr_seq_e state, next_state;
  logic [PCR_CNT_W-1:0] cnt, next_cnt;
  logic [PCR_RESULT_W-1:0] prev_result, next_prev_result;
  logic next_sig_req, next_cls_req, next_det_event, next_clr_sig, next_clr_cls;
  logic active, manual;

  // Cycle scheduler; entering shutdown aborts any pending measurement
  always_comb begin
    active = (mode != PCR_MODE_SHUTDOWN);
    manual = (mode == PCR_MODE_MANUAL);
    next_state = state;
    next_cnt = cnt;
    next_prev_result = prev_result;
    next_sig_req = 1'b0;
    next_cls_req = 1'b0;
    next_det_event = 1'b0;
    next_clr_sig = 1'b0;
    next_clr_cls = 1'b0;
    unique case (state)
      PCR_SEQ_IDLE: begin
        if (active && sig_en) begin
          next_sig_req = 1'b1;
          next_state = PCR_SEQ_SIG;
        end else if (active && cls_en) begin
          next_cls_req = 1'b1;
          next_state = PCR_SEQ_CLS;
        end
      end
      PCR_SEQ_SIG: begin
        if (!active) begin
          next_state = PCR_SEQ_IDLE;
        end else if (sig_done) begin
          // Every result, or only a changed one
          next_det_event = !detect_change || (sig_result != prev_result);
          next_prev_result = sig_result;
          next_clr_sig = manual;
          next_cnt = '0;
          if (cls_en) begin
            next_cls_req = 1'b1;
            next_state = PCR_SEQ_CLS;
          end else begin
            next_state = PCR_SEQ_GAP;
          end
        end
      end
      PCR_SEQ_CLS: begin
        if (!active) begin
          next_state = PCR_SEQ_IDLE;
        end else if (cls_done) begin
          next_clr_cls = manual;
          next_cnt = '0;
          next_state = PCR_SEQ_GAP;
        end
      end
      PCR_SEQ_GAP: begin
        // One idle cycle lets a manual clear land before the next look
        if (!active || !backoff_en || (cnt >= backoff_cycles - 1'b1)) begin
          next_state = PCR_SEQ_IDLE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= PCR_SEQ_IDLE;
      cnt <= '0;
      prev_result <= '0;
      sig_req <= 1'b0;
      cls_req <= 1'b0;
      det_event <= 1'b0;
      clr_sig <= 1'b0;
      clr_cls <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      prev_result <= next_prev_result;
      sig_req <= next_sig_req;
      cls_req <= next_cls_req;
      det_event <= next_det_event;
      clr_sig <= next_clr_sig;
      clr_cls <= next_clr_cls;
    end
  end

endmodule : pcr_port_seq

// ===== pcr_config_regs.sv
`timescale 1ns/10ps
module pcr_config_regs #(
  parameter int NUM_PORTS = pcr_pkg::PCR_NUM_PORTS,
  parameter int CYC_PER_MS = pcr_pkg::PCR_CYC_PER_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access from the management bus engine
  input wire logic [pcr_pkg::PCR_ADDR_W-1:0] reg_addr,
  input wire logic [pcr_pkg::PCR_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pcr_pkg::PCR_DATA_W-1:0] reg_rdata,
  // Measurement engine, per port
  input wire logic [NUM_PORTS-1:0] sig_done,
  input wire logic [NUM_PORTS*pcr_pkg::PCR_RESULT_W-1:0] sig_result,
  input wire logic [NUM_PORTS-1:0] cls_done,
  output logic [NUM_PORTS-1:0] sig_req,
  output logic [NUM_PORTS-1:0] cls_req,
  output logic [NUM_PORTS-1:0] det_event,
  // Port power path
  input wire logic [NUM_PORTS-1:0] power_on,
  input wire logic [NUM_PORTS-1:0] low_current_pin,
  output logic [NUM_PORTS-1:0] drop_power,
  output logic [NUM_PORTS-1:0] direct_current_drop_enable,
  output logic [NUM_PORTS-1:0] emulated_alternating_drop_enable,
  output logic [pcr_pkg::PCR_CNT_W-1:0] startup_timer,
  output logic [pcr_pkg::PCR_CNT_W-1:0] overload_cut_timer,
  // Interrupt pin, open drain
  input wire logic int_pending,
  output logic int_o,
  output logic int_oe_n
);
  import pcr_pkg::*;

  localparam logic [PCR_CNT_W-1:0] CYC_MS = PCR_CNT_W'(CYC_PER_MS);
  localparam logic [PCR_CNT_W-1:0] BACKOFF_CYC = PCR_CNT_W'(PCR_BACKOFF_MS * CYC_MS);

  // Configuration registers
  logic [PCR_DATA_W-1:0] port_operating_mode, next_port_operating_mode;
  logic [PCR_DATA_W-1:0] disconnect_sense_enable, next_disconnect_sense_enable;
  logic [PCR_DATA_W-1:0] detect_class_enable, next_detect_class_enable;
  logic [NUM_PORTS-1:0] backoff_enable, next_backoff_enable;
  logic [PCR_DATA_W-1:0] timer_length_config, next_timer_length_config;
  logic [PCR_DATA_W-1:0] next_reg_rdata;

  // Derived outputs
  logic [PCR_CNT_W-1:0] next_startup_timer, next_overload_cut_timer, dis_cycles;
  logic next_int_oe_n;

  // Sequencer one-shot clears
  logic [NUM_PORTS-1:0] clr_sig, clr_cls;

  logic wr_mode, wr_disc, wr_dcen, wr_backoff, wr_timing, wr_detact;
  logic detect_change, int_enable;

  // Address decode
  always_comb begin
    wr_mode = reg_wr && (reg_addr == PCR_ADDR_MODE);
    wr_disc = reg_wr && (reg_addr == PCR_ADDR_DISC);
    wr_dcen = reg_wr && (reg_addr == PCR_ADDR_DCEN);
    wr_backoff = reg_wr && (reg_addr == PCR_ADDR_BACKOFF);
    wr_timing = reg_wr && (reg_addr == PCR_ADDR_TIMING);
    wr_detact = reg_wr && (reg_addr == PCR_ADDR_DETACT);
    detect_change = timer_length_config[PCR_DETCHG_BIT];
    int_enable = timer_length_config[PCR_INTEN_BIT];
  end

  // Register write paths
  always_comb begin
    next_port_operating_mode = wr_mode ? reg_wdata : port_operating_mode;
    next_disconnect_sense_enable = wr_disc ? reg_wdata : disconnect_sense_enable;
    // Back-off keeps only its port bits
    next_backoff_enable = wr_backoff ? reg_wdata[NUM_PORTS-1:0] : backoff_enable;
    // Timer selects share the byte with detect-change and interrupt enable
    next_timer_length_config = wr_timing ? reg_wdata : timer_length_config;
    // Host action beats the sequencer clear in the same cycle
    next_detect_class_enable = detect_class_enable & ~{clr_cls, clr_sig};
    if (wr_dcen) begin
      next_detect_class_enable = reg_wdata;
    end
    if (wr_detact) begin
      next_detect_class_enable = next_detect_class_enable | reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_operating_mode <= PCR_RST_MODE;
      disconnect_sense_enable <= PCR_RST_DISC;
      detect_class_enable <= PCR_RST_DCEN;
      backoff_enable <= PCR_RST_BACKOFF;
      timer_length_config <= PCR_RST_TIMING;
    end else begin
      port_operating_mode <= next_port_operating_mode;
      disconnect_sense_enable <= next_disconnect_sense_enable;
      detect_class_enable <= next_detect_class_enable;
      backoff_enable <= next_backoff_enable;
      timer_length_config <= next_timer_length_config;
    end
  end

  // Read mux; action register and unmapped offsets read zero
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        PCR_ADDR_MODE: next_reg_rdata = port_operating_mode;
        PCR_ADDR_DISC: next_reg_rdata = disconnect_sense_enable;
        PCR_ADDR_DCEN: next_reg_rdata = detect_class_enable;
        PCR_ADDR_BACKOFF: next_reg_rdata = {{(PCR_DATA_W-NUM_PORTS){1'b0}}, backoff_enable};
        PCR_ADDR_TIMING: next_reg_rdata = timer_length_config;
        default: next_reg_rdata = PCR_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= PCR_RD_ZERO;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Timer lengths in cycles; start and cut are registered so the multiply stays off the output path
  always_comb begin
    next_startup_timer = PCR_CNT_W'(pcr_start_ms(
        timer_length_config[PCR_TSEL_START_LSB +: PCR_TSEL_W]) * CYC_MS);
    next_overload_cut_timer = PCR_CNT_W'(pcr_start_ms(
        timer_length_config[PCR_TSEL_CUT_LSB +: PCR_TSEL_W]) * CYC_MS);
    dis_cycles = PCR_CNT_W'(pcr_dis_ms(
        timer_length_config[PCR_TSEL_DIS_LSB +: PCR_TSEL_W]) * CYC_MS);
    // Low-active enable: drive the pin only when allowed and something is pending
    next_int_oe_n = !(int_enable && int_pending);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      startup_timer <= '0;
      overload_cut_timer <= '0;
      int_oe_n <= 1'b1;
      int_o <= 1'b0;
    end else begin
      startup_timer <= next_startup_timer;
      overload_cut_timer <= next_overload_cut_timer;
      int_oe_n <= next_int_oe_n;
      int_o <= 1'b0; // Open drain only ever pulls low
    end
  end

  // Enable outputs are straight register slices
  assign direct_current_drop_enable = disconnect_sense_enable[NUM_PORTS-1:0];
  assign emulated_alternating_drop_enable = disconnect_sense_enable[PCR_HI_LSB +: NUM_PORTS];

  // Per-port sequencer, low-current synchroniser and disconnect timer
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic sync1, sync2, sync3, low_current, next_low_current;
    logic [PCR_CNT_W-1:0] dis_cnt, next_dis_cnt;
    logic next_drop;

    pcr_port_seq u_seq (
      .clk(clk),
      .rst(rst),
      .mode(pcr_mode_e'(port_operating_mode[p*PCR_MODE_W +: PCR_MODE_W])),
      .sig_en(detect_class_enable[p]),
      .cls_en(detect_class_enable[PCR_HI_LSB + p]),
      .backoff_en(backoff_enable[p]),
      .detect_change(detect_change),
      .backoff_cycles(BACKOFF_CYC),
      .sig_done(sig_done[p]),
      .sig_result(sig_result[p*PCR_RESULT_W +: PCR_RESULT_W]),
      .cls_done(cls_done[p]),
      .sig_req(sig_req[p]),
      .cls_req(cls_req[p]),
      .det_event(det_event[p]),
      .clr_sig(clr_sig[p]),
      .clr_cls(clr_cls[p])
    );

    // Comparator level only counts once the last two stages agree
    always_comb begin
      next_low_current = (sync2 == sync3) ? sync3 : low_current;
      next_dis_cnt = '0;
      next_drop = 1'b0;
      // Count while powered, enabled and under the threshold
      if (power_on[p] && direct_current_drop_enable[p] && low_current) begin
        if (dis_cnt >= dis_cycles - 1'b1) begin
          next_drop = 1'b1;
        end else begin
          next_dis_cnt = dis_cnt + 1'b1;
        end
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        sync1 <= 1'b0;
        sync2 <= 1'b0;
        sync3 <= 1'b0;
        low_current <= 1'b0;
        dis_cnt <= '0;
        drop_power[p] <= 1'b0;
      end else begin
        sync1 <= low_current_pin[p];
        sync2 <= sync1;
        sync3 <= sync2;
        low_current <= next_low_current;
        dis_cnt <= next_dis_cnt;
        drop_power[p] <= next_drop;
      end
    end
  end

endmodule : pcr_config_regs

// ===== pcr_config_regs_assertions.sv
`timescale 1ns/10ps
module pcr_config_regs_chk #(
  parameter int CYC_PER_MS = pcr_pkg::PCR_CYC_PER_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Port sequencing and power
  input wire logic [3:0] sig_req,
  input wire logic [3:0] sig_done,
  input wire logic [3:0] det_event,
  input wire logic [3:0] direct_current_drop_enable,
  input wire logic [3:0] drop_power,
  input wire logic [31:0] startup_timer,
  // Interrupt pin
  input wire logic int_pending,
  input wire logic int_o,
  input wire logic int_oe_n
);
  import pcr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A request waits for its answer, so no new one follows at once
  sequence s_quiet;
    !sig_req[2] [*4];
  endsequence
  sequence s_act_read;
    reg_rd && reg_addr == PCR_ADDR_DETACT;
  endsequence
  rd_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  act_zero_a: assert property (s_act_read |=> reg_rdata == PCR_RD_ZERO)
    else $error("action offset read not zero");
  backoff_hi_a: assert property (reg_rd && reg_addr == PCR_ADDR_BACKOFF
    |=> reg_rdata[7:4] == 4'h0) else $error("reserved back-off bits read set");
  req_spaced_a: assert property (sig_req[2] |=> s_quiet)
    else $error("signature request repeated while waiting");
  det_cause_a: assert property (det_event != 4'h0
    |-> (det_event & ~$past(sig_done)) == 4'h0) else $error("event without detection");
  drop_cause_a: assert property (drop_power != 4'h0
    |-> (drop_power & ~$past(direct_current_drop_enable)) == 4'h0)
    else $error("power dropped on a port without enable");
  // Timer length only takes the four coded values once out of reset
  start_code_a: assert property (!$past(rst) |-> startup_timer inside
    {32'(60 * CYC_PER_MS), 32'(30 * CYC_PER_MS), 32'(120 * CYC_PER_MS),
    32'(240 * CYC_PER_MS)}) else $error("start timer length not coded");
  int_float_a: assert property (!int_oe_n |-> $past(int_pending))
    else $error("interrupt pin pulled with nothing pending");
  int_low_a: assert property (int_o == 1'b0)
    else $error("interrupt pin driven high");
endmodule : pcr_config_regs_chk

bind pcr_config_regs pcr_config_regs_chk #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sig_req(sig_req), .sig_done(sig_done), .det_event(det_event),
  .direct_current_drop_enable(direct_current_drop_enable), .drop_power(drop_power),
  .startup_timer(startup_timer), .int_pending(int_pending), .int_o(int_o),
  .int_oe_n(int_oe_n));

// ===== pcr_meas_model.sv
`timescale 1ns/10ps
module pcr_meas_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests from the port sequencers
  input wire logic [3:0] sig_req,
  input wire logic [3:0] cls_req,
  // Scenario controls
  input wire logic slow,
  input wire logic [11:0] result_in,
  // Answers
  output logic [3:0] sig_done,
  output logic [11:0] sig_result,
  output logic [3:0] cls_done
);
  logic [3:0] s_cnt [4];
  logic [3:0] c_cnt [4];
  // Result bus toggles outside done so a stale code never looks valid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_cnt <= '{default: 4'h0};
      c_cnt <= '{default: 4'h0};
      sig_done <= 4'h0;
      cls_done <= 4'h0;
      sig_result <= 12'h000;
    end else begin
      for (int p = 0; p < 4; p++) begin
        s_cnt[p] <= sig_req[p] ? (slow ? 4'h9 : 4'h3) : s_cnt[p] - 4'(s_cnt[p] != 4'h0);
        c_cnt[p] <= cls_req[p] ? (slow ? 4'h9 : 4'h3) : c_cnt[p] - 4'(c_cnt[p] != 4'h0);
        sig_done[p] <= s_cnt[p] == 4'h1;
        cls_done[p] <= c_cnt[p] == 4'h1;
        sig_result[3*p +: 3] <= (s_cnt[p] == 4'h1) ? result_in[3*p +: 3]
          : ~sig_result[3*p +: 3];
      end
    end
  end
endmodule : pcr_meas_model

// ===== test_pse_port_config_registers.sv
`timescale 1ns/10ps
module test_pse_port_config_registers;
  import pcr_pkg::*;
  logic clk, rst, reg_wr, reg_rd, slow, int_pending;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [3:0] sig_done, cls_done, sig_req, cls_req, det_event, power_on, low_current_pin;
  logic [3:0] drop_power, dce, eac;
  logic [11:0] sig_result, result_in;
  logic [31:0] startup_timer, overload_cut_timer;
  logic int_o, int_oe_n;
  int n_fail = 0, n_compared = 0, cyc = 0, n_drop = 0, n_keep = 0, s0;
  int n_sig [4] = '{default: 0}, n_det [4] = '{default: 0}, n_done [4] = '{default: 0};
  int n_cls [4] = '{default: 0};
  int t_tab [4] = '{60, 30, 120, 240};
  pcr_config_regs #(.NUM_PORTS(4), .CYC_PER_MS(2)) dut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sig_done(sig_done), .sig_result(sig_result),
    .cls_done(cls_done), .sig_req(sig_req), .cls_req(cls_req), .det_event(det_event),
    .power_on(power_on), .low_current_pin(low_current_pin), .drop_power(drop_power),
    .direct_current_drop_enable(dce), .emulated_alternating_drop_enable(eac),
    .startup_timer(startup_timer), .overload_cut_timer(overload_cut_timer),
    .int_pending(int_pending), .int_o(int_o), .int_oe_n(int_oe_n));
  pcr_meas_model u_meas (.clk(clk), .rst(rst), .sig_req(sig_req), .cls_req(cls_req),
    .slow(slow), .result_in(result_in), .sig_done(sig_done), .sig_result(sig_result),
    .cls_done(cls_done));
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Pulse tallies and hang guard
  always @(posedge clk) begin
    for (int p = 0; p < 4; p++) begin
      n_sig[p] += int'(sig_req[p]);
      n_det[p] += int'(det_event[p]);
      n_done[p] += int'(sig_done[p]);
      n_cls[p] += int'(cls_req[p]);
    end
    n_drop += int'(drop_power[0]);
    n_keep += int'(drop_power[1]);
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      conclude();
    end
  end
  // Extra idle edge so two strobes never land in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask : rd
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk8
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk32
  task automatic conclude();
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    {rst, reg_wr, reg_rd, slow, int_pending} = 5'b1_0000;
    {reg_addr, reg_wdata, power_on, low_current_pin} = 24'h00_0000;
    result_in = 12'h924;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 8'h12; a <= 8'h18; a++) begin
      rd(8'(a), d);
      chk8(d, 8'h00);
    end
    chk32(startup_timer, 32'h0000_0078);
    wr(8'h12, 8'hE4);
    rd(8'h12, d);
    chk8(d, 8'hE4);
    wr(8'h13, 8'hA5);
    chk8({eac, dce}, 8'hA5);
    wr(8'h15, 8'hFF);
    rd(8'h15, d);
    chk8(d, 8'h0F);
    wr(8'h40, 8'hFF);
    rd(8'h40, d);
    chk8(d, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(8'h16, {4'h1, 2'(s), 2'(s)});
      // Timer lengths sit one register behind the select byte
      @(posedge clk);
      chk32(startup_timer, 32'(t_tab[s] * 2));
      chk32(overload_cut_timer, 32'(t_tab[s] * 2));
    end
    rd(8'h16, d);
    chk8(d, 8'h1F);
    wr(8'h15, 8'h00);
    // Port 0 shutdown, 1 manual, 2 software, 3 hardware class only
    wr(8'h18, 8'h87);
    repeat (200) @(posedge clk);
    wr(8'h14, 8'h01);
    repeat (30) @(posedge clk);
    chk32(32'(n_cls[3] >= 3), 1);
    chk32(n_sig[0], 0);
    chk32(n_sig[1], 1);
    chk32(n_det[1], 1);
    chk32(32'(n_sig[2] >= 3), 1);
    chk32(n_det[2], n_done[2]);
    rd(8'h14, d);
    chk8(d, 8'h01);
    // Same code twice gives no event while change filter is on
    wr(8'h16, 8'h5F);
    s0 = n_det[2];
    slow <= 1'b1;
    wr(8'h14, 8'h04);
    repeat (100) @(posedge clk);
    chk32(n_det[2] - s0, 0);
    // Port 2 code moves from 4 to 5; every other field may stay
    result_in <= 12'h964;
    repeat (100) @(posedge clk);
    chk32(n_det[2] - s0, 1);
    wr(8'h15, 8'h04);
    s0 = n_sig[2];
    repeat (4000) @(posedge clk);
    chk32(32'(n_sig[2] - s0 <= 1), 1);
    // A request just before s0 puts the next two near 5012 and 10024
    repeat (7000) @(posedge clk);
    chk32(32'(n_sig[2] - s0 >= 2), 1);
    wr(8'h14, 8'h00);
    // Disconnect at 90 ms select; port 1 lacks enable and must stay up
    power_on <= 4'h3;
    low_current_pin <= 4'h3;
    repeat (170) @(posedge clk);
    chk32(n_drop, 0);
    repeat (20) @(posedge clk);
    chk32(n_drop, 1);
    chk32(n_keep, 0);
    int_pending <= 1'b1;
    repeat (3) @(posedge clk);
    chk8({7'h00, int_oe_n}, 8'h01);
    wr(8'h16, 8'hDF);
    // Pin enable follows the register one clock later
    @(posedge clk);
    chk8({6'h00, int_o, int_oe_n}, 8'h00);
    conclude();
  end
endmodule : test_pse_port_config_registers
